// ---- stp_params.svh ----
// Register map, field positions and timing constants for the stepper controller
`ifndef STP_PARAMS_SVH
`define STP_PARAMS_SVH

`define STP_F_CLK_HZ 125000000
`define STP_MAX_PPS 10000
`define STP_START_SHIFT 3

`define STP_SEL_HI 7
`define STP_SEL_LO 4
`define STP_REG_HI 3
`define STP_REG_LO 0
`define STP_SEL_GLOBAL 4'h0

`define STP_G_FLAGS 4'h0
`define STP_G_GPO 4'h1
`define STP_G_MODE 4'h2

`define STP_C_RATE 4'h0
`define STP_C_RAMP 4'h1
`define STP_C_FSEL 4'h2
`define STP_C_REL 4'h3
`define STP_C_ABS 4'h4
`define STP_C_CMD 4'h5
`define STP_C_LOC 4'h6
`define STP_C_MOVED 4'h7
`define STP_C_STAT 4'h8

`define STP_CMD_ABORT_BIT 0
`define STP_CMD_HOME_BIT 1
`define STP_STAT_BUSY_BIT 0
`define STP_STAT_MODE_BIT 1

`define STP_GPO_DIR_BIT 0
`define STP_GPO_STEP_BIT 4

`define STP_GPO_RST 8'h00
`define STP_FLAGS_RST 32'h0000_0000

`endif

// ---- stp_pkg.sv ----
// Types shared by the stepper controller modules
package stp_pkg;
    typedef logic [7:0] stp_addr_t;
    typedef logic [31:0] stp_word_t;
    typedef enum logic {ST_IDLE, ST_RUN} stp_state_t;
endpackage : stp_pkg

// ---- stp_ch_if.sv ----
// Command and status bundle between the register file and one channel
`timescale 1ns/1ps
interface stp_ch_if #(parameter int RATE_W = 14);
    logic start;
    logic dir;
    logic abort;
    logic home;
    logic [31:0] count;
    logic [RATE_W-1:0] top_rate;
    logic [31:0] ramp_steps;
    logic busy;
    logic done;
    logic step;
    logic dir_o;
    logic [31:0] loc;
    logic [31:0] moved;
    modport ctl (output start, dir, abort, home, count, top_rate, ramp_steps,
        input busy, done, step, dir_o, loc, moved);
    modport chn (input start, dir, abort, home, count, top_rate, ramp_steps,
        output busy, done, step, dir_o, loc, moved);
endinterface : stp_ch_if

// ---- stp_channel.sv ----
// One pulse/direction channel with trapezoidal rate profile and location counter
`timescale 1ns/1ps
`include "stp_params.svh"
module stp_channel #(
    parameter int RATE_W = 14
) (
    input wire logic clk,
    input wire logic reset_n,
    stp_ch_if.chn ch
);
    import stp_pkg::*;

    localparam logic [27:0] F_CLK = 28'(`STP_F_CLK_HZ);
    localparam logic [27:0] HALF = 28'(`STP_F_CLK_HZ / 2);
    localparam logic [RATE_W-1:0] MAX_RATE = RATE_W'(`STP_MAX_PPS);

    stp_state_t state_r;
    logic [RATE_W-1:0] v_r, vmax_r, vmin_r, vtop, vstart;
    logic [26:0] ph_r;
    logic [27:0] ph_nxt;
    logic [63:0] err_r, den_r, err_nxt;
    logic [31:0] rem_r, up_r, loc_r, moved_r, ramp_eff;
    logic step_r, dir_r, done_r;
    logic run, go, rise, wrap, decel, accel, slow;

    always_comb begin
        // Rate clamped so no channel ever exceeds the pulse ceiling
        if (ch.top_rate > MAX_RATE) vtop = MAX_RATE; // RULE_02
        else if (ch.top_rate == '0) vtop = RATE_W'(1);
        else vtop = ch.top_rate;
        vstart = vtop >> `STP_START_SHIFT; // RULE_03
        if (vstart == '0) vstart = RATE_W'(1);
        ramp_eff = (ch.ramp_steps == '0) ? 32'h1 : ch.ramp_steps;
    end

    assign run = (state_r == ST_RUN);
    assign go = ch.start && !run && ch.count != '0; // RULE_21
    assign ph_nxt = {1'b0, ph_r} + 28'(v_r);
    assign wrap = run && ph_nxt >= F_CLK;
    assign rise = run && !ch.abort && !step_r && ph_nxt >= HALF && rem_r != '0;
    // Decelerate once remaining steps match the steps spent speeding up
    assign decel = rem_r <= up_r; // RULE_12
    assign accel = run && !decel && v_r < vmax_r;
    assign slow = run && decel && v_r > vmin_r;
    assign err_nxt = err_r + 64'(vmax_r) * 64'(vmax_r);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (go) state_r <= ST_RUN;
                    if (ch.start && ch.count == '0) done_r <= 1'b1;
                end
                ST_RUN: begin
                    if (ch.abort) begin
                        state_r <= ST_IDLE; // RULE_23
                    end else if (wrap && rem_r == '0) begin
                        state_r <= ST_IDLE;
                        done_r <= 1'b1; // RULE_16
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rem_r <= '0;
            up_r <= '0;
            moved_r <= '0;
            dir_r <= 1'b0;
        end else if (go) begin
            rem_r <= ch.count; // RULE_14
            up_r <= '0;
            moved_r <= '0;
            dir_r <= ch.dir; // RULE_06
        end else if (rise) begin
            rem_r <= rem_r - 32'h1;
            moved_r <= moved_r + 32'h1;
            if (accel) up_r <= up_r + 32'h1;
        end
    end

    // Constant acceleration V*V/(2S): error accumulator against 2*S*F_CLK
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            v_r <= RATE_W'(1);
            vmax_r <= RATE_W'(1);
            vmin_r <= RATE_W'(1);
            err_r <= '0;
            den_r <= '0;
        end else if (go) begin
            v_r <= vstart; // RULE_03
            vmax_r <= vtop;
            vmin_r <= vstart;
            err_r <= '0;
            den_r <= {31'h0, ramp_eff, 1'b0} * 64'(F_CLK); // RULE_13
        end else if (accel || slow) begin
            if (err_nxt >= den_r) begin
                err_r <= err_nxt - den_r;
                if (accel) v_r <= v_r + RATE_W'(1);
                else v_r <= v_r - RATE_W'(1);
            end else begin
                err_r <= err_nxt;
            end
        end else begin
            err_r <= '0;
        end
    end

    // High from mid-period to period end gives about half-period pulses
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ph_r <= '0;
            step_r <= 1'b0;
        end else if (go || (run && ch.abort)) begin
            ph_r <= '0;
            step_r <= 1'b0; // RULE_23
        end else if (wrap) begin
            ph_r <= 27'(ph_nxt - F_CLK);
            step_r <= 1'b0; // RULE_22
        end else if (run) begin
            ph_r <= ph_nxt[26:0];
            if (rise) step_r <= 1'b1; // RULE_22
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            loc_r <= '0;
        end else if (ch.home && !run) begin
            loc_r <= '0; // RULE_18
        end else if (rise) begin
            loc_r <= dir_r ? loc_r - 32'h1 : loc_r + 32'h1; // RULE_22
        end
    end

    assign ch.busy = run;
    assign ch.done = done_r;
    assign ch.step = step_r;
    assign ch.dir_o = dir_r;
    assign ch.loc = loc_r;
    assign ch.moved = moved_r;
endmodule : stp_channel

// ---- stp_ctrl.sv ----
// Three-channel stepper pulse/direction controller with register port
`timescale 1ns/1ps
`include "stp_params.svh"
// What this block does
// RULE_01: Three channels, each own step and direction
// RULE_02: Step rate never above 10000 per second
// RULE_03: Trapezoid from eighth rate, up, down
// RULE_04: Moves of 2 to 2^31 pulses
// RULE_05: Only direction level and step train driven
// RULE_06: Direction high when moving negative
// RULE_07: Channel one takes general outputs 1, 5
// RULE_08: Selector 1..3 picks channel, controller mode
// RULE_09: Host loads profile before any move
// RULE_10: Profile lost at power-down, kept by reset
// RULE_11: Host sets top rate 1 to 10000
// RULE_12: Same step count ramps up and down
// RULE_13: Acceleration is rate squared over 2S
// RULE_14: Signed relative move emits magnitude pulses
// RULE_15: Move start clears its completion flag
// RULE_16: Last pulse sets chosen completion flag
// RULE_17: Absolute targets signed 32-bit from home
// RULE_18: Home makes current location zero
// RULE_19: Absolute move from target minus location
// RULE_20: Location readable at any time
// RULE_21: Moves ignored while a move runs
// RULE_22: Half-period pulses, location tracks each pulse
// RULE_23: Abort halts at once, flag stays clear
module stp_ctrl #(
    parameter int NUM_CH = 3,
    parameter int RATE_W = 14,
    parameter int FLAG_W = 5
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire stp_pkg::stp_addr_t addr,
    input wire stp_pkg::stp_word_t wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output stp_pkg::stp_word_t rdata,
    output logic [NUM_CH-1:0] step_out,
    output logic [NUM_CH-1:0] dir_out,
    output logic [7:0] gen_out
);
    import stp_pkg::*;

    localparam int NFLAGS = 1 << FLAG_W;

    logic [3:0] sel, rsel;
    logic [RATE_W-1:0] rate_r [NUM_CH];
    logic [31:0] ramp_r [NUM_CH];
    logic [FLAG_W-1:0] fsel_r [NUM_CH];
    logic [FLAG_W-1:0] afsel_r [NUM_CH];
    logic [31:0] cnt_r [NUM_CH];
    logic [NUM_CH-1:0] start_r, abort_r, home_r, dcmd_r, mode_r;
    logic [NUM_CH-1:0] hit, mv_acc, busy_v, done_v, step_v, dir_v;
    logic [31:0] loc_v [NUM_CH];
    logic [31:0] moved_v [NUM_CH];
    logic [7:0] gpo_r;
    logic [NFLAGS-1:0] flags_r, flags_nxt, flag_set, flag_clr;
    stp_word_t rdata_r;
    logic [NUM_CH-1:0] step_q, dir_q;
    logic [7:0] gen_q;

    // Magnitude and sign of a 33-bit signed distance
    function automatic logic [32:0] dist_split(input logic [32:0] d);
        logic [32:0] m;
        m = d[32] ? 33'(-d) : d;
        return {d[32], m[31:0]};
    endfunction : dist_split

    function automatic logic is_move(input logic [3:0] r);
        return (r == `STP_C_REL) || (r == `STP_C_ABS);
    endfunction : is_move

    assign sel = addr[`STP_SEL_HI:`STP_SEL_LO]; // RULE_08
    assign rsel = addr[`STP_REG_HI:`STP_REG_LO];

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            hit[i] = wr_en && sel == 4'(i + 1); // RULE_08
            // A start already queued counts as busy too
            mv_acc[i] = hit[i] && is_move(rsel) && !busy_v[i] && !start_r[i]; // RULE_21
        end
    end

    // Profile settings skip reset so a soft reset keeps them
    always_ff @(posedge clk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (hit[i] && rsel == `STP_C_RATE) rate_r[i] <= wdata[RATE_W-1:0]; // RULE_10
            if (hit[i] && rsel == `STP_C_RAMP) ramp_r[i] <= wdata; // RULE_10
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                fsel_r[i] <= '0;
                afsel_r[i] <= '0;
            end
            mode_r <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (hit[i] && rsel == `STP_C_FSEL) fsel_r[i] <= wdata[FLAG_W-1:0];
                if (mv_acc[i]) begin
                    afsel_r[i] <= fsel_r[i];
                    mode_r[i] <= 1'b1; // RULE_08
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        logic [32:0] ds;
        ds = '0;
        if (!reset_n) begin
            start_r <= '0;
            abort_r <= '0;
            home_r <= '0;
            dcmd_r <= '0;
            for (int i = 0; i < NUM_CH; i++) cnt_r[i] <= '0;
        end else begin
            start_r <= '0;
            abort_r <= '0;
            home_r <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (mv_acc[i]) begin
                    if (rsel == `STP_C_REL) begin
                        ds = dist_split({wdata[31], wdata}); // RULE_14
                    end else begin // RULE_17
                        ds = dist_split({wdata[31], wdata} - {loc_v[i][31], loc_v[i]}); // RULE_19
                    end
                    start_r[i] <= 1'b1;
                    dcmd_r[i] <= ds[32]; // RULE_06
                    cnt_r[i] <= ds[31:0]; // RULE_04
                end
                if (hit[i] && rsel == `STP_C_CMD) begin
                    abort_r[i] <= wdata[`STP_CMD_ABORT_BIT]; // RULE_23
                    home_r[i] <= wdata[`STP_CMD_HOME_BIT]; // RULE_18
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) gpo_r <= `STP_GPO_RST;
        else if (wr_en && sel == `STP_SEL_GLOBAL && rsel == `STP_G_GPO) gpo_r <= wdata[7:0];
    end

    // Completion flags: a set in the same cycle as a clear wins
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        if (wr_en && sel == `STP_SEL_GLOBAL && rsel == `STP_G_FLAGS) begin
            flag_clr = wdata[NFLAGS-1:0];
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (mv_acc[i]) flag_clr[fsel_r[i]] = 1'b1; // RULE_15
            if (done_v[i]) flag_set[afsel_r[i]] = 1'b1; // RULE_16
        end
        flags_nxt = (flags_r & ~flag_clr) | flag_set;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) flags_r <= `STP_FLAGS_RST;
        else flags_r <= flags_nxt;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_r <= '0;
        end else if (rd_en) begin
            rdata_r <= '0;
            if (sel == `STP_SEL_GLOBAL) begin
                case (rsel)
                    `STP_G_FLAGS: rdata_r <= 32'(flags_r);
                    `STP_G_GPO: rdata_r <= 32'(gpo_r);
                    `STP_G_MODE: rdata_r <= 32'(mode_r);
                    default: rdata_r <= '0;
                endcase
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (sel == 4'(i + 1)) begin
                    case (rsel)
                        `STP_C_RATE: rdata_r <= 32'(rate_r[i]);
                        `STP_C_RAMP: rdata_r <= ramp_r[i];
                        `STP_C_FSEL: rdata_r <= 32'(fsel_r[i]);
                        `STP_C_LOC: rdata_r <= loc_v[i]; // RULE_20
                        `STP_C_MOVED: rdata_r <= moved_v[i];
                        `STP_C_STAT: begin
                            rdata_r[`STP_STAT_BUSY_BIT] <= busy_v[i] | start_r[i];
                            rdata_r[`STP_STAT_MODE_BIT] <= mode_r[i];
                        end
                        default: rdata_r <= '0;
                    endcase
                end
            end
        end
    end

    stp_ch_if #(.RATE_W(RATE_W)) ch_if [NUM_CH] ();

    genvar g;
    for (g = 0; g < NUM_CH; g++) begin : g_ch
        assign ch_if[g].start = start_r[g];
        assign ch_if[g].dir = dcmd_r[g];
        assign ch_if[g].abort = abort_r[g];
        assign ch_if[g].home = home_r[g];
        assign ch_if[g].count = cnt_r[g];
        assign ch_if[g].top_rate = rate_r[g];
        assign ch_if[g].ramp_steps = ramp_r[g];
        assign busy_v[g] = ch_if[g].busy;
        assign done_v[g] = ch_if[g].done;
        assign step_v[g] = ch_if[g].step;
        assign dir_v[g] = ch_if[g].dir_o;
        assign loc_v[g] = ch_if[g].loc;
        assign moved_v[g] = ch_if[g].moved;
        stp_channel #(.RATE_W(RATE_W)) u_ch (
            .clk(clk),
            .reset_n(reset_n),
            .ch(ch_if[g].chn)
        ); // RULE_01
    end

    // Pins carry only step and direction; coil drive stays external
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            step_q <= '0;
            dir_q <= '0;
            gen_q <= `STP_GPO_RST;
        end else begin
            step_q <= step_v; // RULE_05
            dir_q <= dir_v; // RULE_06
            gen_q <= gpo_r;
            if (mode_r[0]) begin
                gen_q[`STP_GPO_DIR_BIT] <= dir_v[0]; // RULE_07
                gen_q[`STP_GPO_STEP_BIT] <= step_v[0]; // RULE_07
            end
        end
    end

    assign rdata = rdata_r;
    assign step_out = step_q;
    assign dir_out = dir_q;
    assign gen_out = gen_q;
endmodule : stp_ctrl

// ---- stp_ctrl_asserts.sv ----
// Port-level assertions for the stepper controller
`timescale 1ns/1ps
module stp_ctrl_asserts #(
    parameter int NUM_CH = 3,
    parameter int RATE_W = 14,
    parameter int FLAG_W = 5
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire stp_pkg::stp_addr_t addr,
    input wire stp_pkg::stp_word_t wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire stp_pkg::stp_word_t rdata,
    input wire logic [NUM_CH-1:0] step_out,
    input wire logic [NUM_CH-1:0] dir_out,
    input wire logic [7:0] gen_out
);
    import stp_pkg::*;
    logic prev_r;
    logic [15:0] gap_r;
    // Saturates so a long idle spell never trips the rate check
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prev_r <= 1'b0;
            gap_r <= 16'hffff;
        end else begin
            prev_r <= step_out[0];
            if (step_out[0] && !prev_r) begin
                gap_r <= 16'h0000;
            end else if (gap_r != 16'hffff) begin
                gap_r <= gap_r + 16'h0001;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_unmapped_read_zero: assert property (rd_en && addr[7:4] > 4'h3 |=> rdata == 32'h0)
        else $error("unmapped selector read not zero");
    a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
        else $error("read data moved without a read");
    a_step_rate_cap: assert property (step_out[0] && !prev_r |-> gap_r >= 16'h30d3)
        else $error("step pulses closer than 12500 cycles");
    a_step_high_len: assert property ($rose(step_out[0]) |-> step_out[0] [*8])
        else $error("step pulse too short");
    a_dir_steady_pulse: assert property (step_out[0] && $past(step_out[0]) |-> $stable(dir_out[0]))
        else $error("direction changed during a step pulse");
    a_gen_step_map: assert property ($rose(step_out[0]) |-> ##[0:1] gen_out[4])
        else $error("general output 5 not following step");
    a_gen_dir_map: assert property (step_out[0] |-> ##1 gen_out[0] == dir_out[0])
        else $error("general output 1 not following direction");
    a_abort_halts: assert property (wr_en && addr == 8'h15 && wdata[0] |-> ##4 !step_out[0] [*8])
        else $error("steps continue after abort");
endmodule : stp_ctrl_asserts

bind stp_ctrl stp_ctrl_asserts #(.NUM_CH(NUM_CH), .RATE_W(RATE_W), .FLAG_W(FLAG_W))
    stp_ctrl_asserts_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .step_out(step_out), .dir_out(dir_out),
    .gen_out(gen_out));

// ---- stp_drv_model.sv ----
// Behavioural step/direction power stage tracking shaft position
`timescale 1ns/1ps
module stp_drv_model (
    input wire logic clk,
    input wire logic step,
    input wire logic dir,
    output logic signed [31:0] pos
);
    logic step_d;
    initial begin
        pos = 32'h0;
        step_d = 1'b0;
    end
    // Coil sequencing is left out here and in the controller; only edges count
    always @(posedge clk) begin
        step_d <= step;
        if (step && !step_d) begin
            pos <= dir ? pos - 32'sh1 : pos + 32'sh1;
        end
    end
endmodule : stp_drv_model

// ---- stp_ctrl_tb.sv ----
// Self-checking bench for the three-channel stepper controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module stp_ctrl_tb;
    import stp_pkg::*;
    logic clk;
    logic reset_n;
    stp_addr_t addr;
    stp_word_t wdata;
    logic wr_en;
    logic rd_en;
    stp_word_t rdata;
    logic [2:0] step_out;
    logic [2:0] dir_out;
    logic [7:0] gen_out;
    logic signed [31:0] pos [3];
    int err_total;
    int tests_run;
    stp_word_t v;

    stp_ctrl stp_ctrl_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .step_out(step_out),
        .dir_out(dir_out), .gen_out(gen_out));
    for (genvar g = 0; g < 3; g++) begin : gen_drv
        stp_drv_model stp_drv_model_i (.clk(clk), .step(step_out[g]), .dir(dir_out[g]),
            .pos(pos[g]));
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim;
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input stp_addr_t a, input stp_word_t d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        // Idle edge keeps the strobe from being set twice in one step
        @(posedge clk);
    endtask : wr

    // Read data stand from the cycle after the strobe until the next read
    task automatic rd(input stp_addr_t a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask : rd

    task automatic chk_rd(input string nm, input stp_addr_t a, input stp_word_t ex);
        rd(a);
        `CHK(nm, ex, v)
    endtask : chk_rd

    task automatic prof(input logic [3:0] c, input stp_word_t fsel);
        wr({c, 4'h0}, 32'h2710);
        wr({c, 4'h1}, 32'h1);
        wr({c, 4'h2}, fsel);
    endtask : prof

    // A move at the slowest start rate can take many thousand cycles
    task automatic wait_flag(input int b);
        for (int n = 0; n < 75000; n++) begin
            rd(8'h00);
            if (v[b] === 1'b1) begin
                return;
            end
        end
        err_total++;
        $display("[FAIL] completion flag %0d never set", b);
        end_sim();
    endtask : wait_flag

    task automatic t_after_reset;
        chk_rd("flags", 8'h00, 32'h0);
        chk_rd("mode", 8'h02, 32'h0);
        chk_rd("loc1", 8'h16, 32'h0);
        chk_rd("unmapped", 8'h0f, 32'h0);
        chk_rd("sel4", 8'h40, 32'h0);
        wr(8'h01, 32'h5a);
        chk_rd("gpo", 8'h01, 32'h5a);
        @(negedge clk);
        `CHK("gen_out", 8'h5a, gen_out)
        `CHK("pins idle", 6'h00, {step_out, dir_out})
        @(posedge clk);
    endtask : t_after_reset

    task automatic t_zero_move;
        prof(4'h2, 32'h3);
        wr(8'h23, 32'h0);
        repeat (4) @(posedge clk);
        chk_rd("flag set", 8'h00, 32'h8);
        wr(8'h23, 32'h0);
        chk_rd("flag cleared", 8'h00, 32'h0);
        repeat (4) @(posedge clk);
        wr(8'h00, 32'h8);
        chk_rd("flag w1c", 8'h00, 32'h0);
        chk_rd("mode ch2", 8'h02, 32'h2);
        @(negedge clk);
        `CHK("ch2 idle", 1'b0, step_out[1])
        @(posedge clk);
    endtask : t_zero_move

    task automatic t_abort;
        prof(4'h1, 32'h7);
        wr(8'h13, 32'h64);
        repeat (20) @(posedge clk);
        chk_rd("busy", 8'h18, 32'h3);
        wr(8'h15, 32'h1);
        repeat (8) @(posedge clk);
        @(negedge clk);
        `CHK("step1", 1'b0, step_out[0])
        `CHK("dir pos", 1'b0, dir_out[0])
        `CHK("gen map", 8'h4a, gen_out)
        @(posedge clk);
        chk_rd("idle", 8'h18, 32'h2);
        chk_rd("no flag", 8'h00, 32'h0);
        chk_rd("loc", 8'h16, 32'h0);
    endtask : t_abort

    // Second move is written while the first is pending and must vanish
    task automatic t_rel_back;
        wr(8'h12, 32'h5);
        // Strobe held high across both writes, no gap
        addr <= 8'h13;
        wdata <= 32'hffff_fffe;
        wr_en <= 1'b1;
        @(posedge clk);
        wdata <= 32'h5;
        @(posedge clk);
        wr_en <= 1'b0;
        wait_flag(5);
        @(negedge clk);
        `CHK("pulses", 32'hffff_fffe, pos[0])
        `CHK("dir neg", 1'b1, dir_out[0])
        `CHK("gen dir", 8'h4b, gen_out)
        @(posedge clk);
        chk_rd("loc", 8'h16, 32'hffff_fffe);
        chk_rd("moved", 8'h17, 32'h2);
        wr(8'h15, 32'h2);
        chk_rd("home", 8'h16, 32'h0);
        wr(8'h14, 32'h0);
        repeat (4) @(posedge clk);
        chk_rd("abs same", 8'h00, 32'h20);
        @(negedge clk);
        `CHK("no pulse", 32'hffff_fffe, pos[0])
        @(posedge clk);
        // Positive target from home flips direction, then abort it
        wr(8'h14, 32'h3);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("abs fwd dir", 1'b0, dir_out[0])
        @(posedge clk);
        chk_rd("abs busy", 8'h18, 32'h3);
        wr(8'h15, 32'h1);
    endtask : t_rel_back

    task automatic t_soft_reset;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk_rd("rate kept", 8'h10, 32'h2710);
        chk_rd("ramp kept", 8'h11, 32'h1);
        chk_rd("flags clr", 8'h00, 32'h0);
        @(negedge clk);
        `CHK("gen clr", 8'h00, gen_out)
        @(posedge clk);
    endtask : t_soft_reset

    initial begin
        reset_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_after_reset();
        t_zero_move();
        t_abort();
        t_rel_back();
        t_soft_reset();
        end_sim();
    end
endmodule : stp_ctrl_tb
